// ==== rtl/vlm_pkg.sv ====
// Constants for the output-voltage ceiling and margin-high register bank.
// Assumes command codes arrive already framed by the bus transport.
package vlm_pkg;
    localparam int VLM_DATA_W = 16;
    localparam int VLM_CODE_W = 8;
    localparam logic [VLM_CODE_W-1:0] VLM_CMD_CEILING = 8'h24;
    localparam logic [VLM_CODE_W-1:0] VLM_CMD_MARGIN_HIGH = 8'h25;
    localparam logic [VLM_DATA_W-1:0] VLM_CEILING_RST = 16'h08FC;
    localparam logic [VLM_DATA_W-1:0] VLM_MARGIN_HIGH_RST = 16'h0640;
    localparam logic [VLM_DATA_W-1:0] VLM_CEILING_SPAN_MAX = 16'h0CE4;
    localparam int VLM_DATA_BYTES = 2;
    typedef enum logic [1:0] {
        VLM_SEL_NONE = 2'h0,
        VLM_SEL_CEILING = 2'h1,
        VLM_SEL_MARGIN_HIGH = 2'h3
    } vlm_sel_t;
endpackage

// ==== rtl/vlm_regs.sv ====
// Paged output-voltage ceiling and margin-high setpoint registers.
// Assumes the transport delivers whole two-byte words with a page index,
// and that all inputs come from logic on CLK.
// One access is taken per clock and answered one clock later.
// Notes on behaviour
// - Effective target of each page never exceeds the ceiling that page held one clock earlier.
// - Margin-high selection makes the page setpoint the requested target.
// - Both registers are paged, one copy per output, two-byte words.
// - Both are read/write 16-bit unsigned millivolt values, one count each.
// - Ceiling of every page resets to 08FCh, 2300 millivolts.
// - Ceiling is meant to be programmed between 0 and 3300 millivolts.
// - Margin-high setpoint of every page resets to 0640h, 1600 millivolts.
// - Setpoint is meant to lie between page minimum and page ceiling.
`timescale 1ns/100ps
`default_nettype none
module vlm_regs
    import vlm_pkg::*;
#(
    parameter int PAGES = 2,
    parameter int PAGE_W = 1
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // Command access
    input wire logic [PAGE_W-1:0] PAGE,
    input wire logic [VLM_CODE_W-1:0] CMD_CODE,
    input wire logic WR_EN,
    input wire logic [VLM_DATA_W-1:0] WR_DATA,
    input wire logic RD_EN,
    output logic [VLM_DATA_W-1:0] RD_DATA,
    output logic RD_VALID,
    output logic CMD_REJECT,
    output logic RANGE_WARN,
    // Regulation target path, one slice per page
    input wire logic [PAGES*VLM_DATA_W-1:0] NOMINAL_TARGET,
    input wire logic [PAGES-1:0] MARGIN_HIGH_SEL,
    output logic [PAGES*VLM_DATA_W-1:0] TARGET,
    output logic [PAGES-1:0] CLAMPED,
    output logic [PAGES*VLM_DATA_W-1:0] CEILING
);

    function automatic vlm_sel_t decode(input logic [VLM_CODE_W-1:0] code);
        if (code == VLM_CMD_CEILING) begin
            decode = VLM_SEL_CEILING;
        end else if (code == VLM_CMD_MARGIN_HIGH) begin
            decode = VLM_SEL_MARGIN_HIGH;
        end else begin
            decode = VLM_SEL_NONE;
        end
    endfunction

    // Unsigned compare shared by the clamp and the range warnings
    function automatic logic exceeds(
        input logic [VLM_DATA_W-1:0] value,
        input logic [VLM_DATA_W-1:0] limit
    );
        exceeds = (value > limit);
    endfunction

    // Word of the addressed register for a read
    function automatic logic [VLM_DATA_W-1:0] pick_word(
        input vlm_sel_t which,
        input logic [VLM_DATA_W-1:0] ceil_word,
        input logic [VLM_DATA_W-1:0] margin_word
    );
        if (which == VLM_SEL_CEILING) begin
            pick_word = ceil_word;
        end else begin
            pick_word = margin_word;
        end
    endfunction

    logic [VLM_DATA_W-1:0] ceiling_r [PAGES];
    logic [VLM_DATA_W-1:0] ceiling_nxt [PAGES];
    logic [VLM_DATA_W-1:0] margin_r [PAGES];
    logic [VLM_DATA_W-1:0] margin_nxt [PAGES];
    logic [VLM_DATA_W-1:0] rd_data_r;
    logic [VLM_DATA_W-1:0] rd_data_nxt;
    logic rd_valid_r;
    logic rd_valid_nxt;
    logic reject_r;
    logic reject_nxt;
    logic warn_r;
    logic warn_nxt;
    logic [VLM_DATA_W-1:0] target_r [PAGES];
    logic [VLM_DATA_W-1:0] target_nxt [PAGES];
    logic [PAGES-1:0] clamped_r;
    logic [PAGES-1:0] clamped_nxt;
    vlm_sel_t sel;
    logic page_ok;
    logic take_ok;
    logic wr_take;
    logic rd_take;

    assign sel = decode(CMD_CODE);
    assign page_ok = (int'(PAGE) < PAGES);
    // Unknown code or page refuses the access outright
    assign take_ok = (sel != VLM_SEL_NONE) && page_ok;
    // A write wins when both strobes are high
    assign wr_take = WR_EN && take_ok;
    assign rd_take = RD_EN && !WR_EN && take_ok;

    // Register file: one copy of each word per page
    always_comb begin
        for (int p = 0; p < PAGES; p++) begin
            ceiling_nxt[p] = ceiling_r[p];
            margin_nxt[p] = margin_r[p];
            if (wr_take && int'(PAGE) == p) begin
                if (sel == VLM_SEL_CEILING) begin
                    ceiling_nxt[p] = WR_DATA;
                end else begin
                    margin_nxt[p] = WR_DATA;
                end
            end
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            for (int p = 0; p < PAGES; p++) begin
                ceiling_r[p] <= VLM_CEILING_RST;
                margin_r[p] <= VLM_MARGIN_HIGH_RST;
            end
        end else begin
            for (int p = 0; p < PAGES; p++) begin
                ceiling_r[p] <= ceiling_nxt[p];
                margin_r[p] <= margin_nxt[p];
            end
        end
    end

    // Access answers one clock after the strobe; valid, reject and warning are pulses
    always_comb begin
        // RD_DATA keeps the last word read
        rd_data_nxt = rd_data_r;
        rd_valid_nxt = rd_take;
        reject_nxt = (WR_EN || RD_EN) && !take_ok;
        warn_nxt = 1'b0;
        if (wr_take) begin
            // Out-of-span words are kept; the pulse only warns
            if (sel == VLM_SEL_CEILING) begin
                warn_nxt = exceeds(WR_DATA, VLM_CEILING_SPAN_MAX);
            end else begin
                warn_nxt = exceeds(WR_DATA, ceiling_r[PAGE]);
            end
        end
        if (rd_take) begin
            rd_data_nxt = pick_word(sel, ceiling_r[PAGE], margin_r[PAGE]);
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            rd_data_r <= '0;
            rd_valid_r <= 1'b0;
            reject_r <= 1'b0;
            warn_r <= 1'b0;
        end else begin
            rd_data_r <= rd_data_nxt;
            rd_valid_r <= rd_valid_nxt;
            reject_r <= reject_nxt;
            warn_r <= warn_nxt;
        end
    end

    // Target selection and clamp per page
    always_comb begin
        logic [VLM_DATA_W-1:0] req;
        req = '0;
        for (int p = 0; p < PAGES; p++) begin
            req = NOMINAL_TARGET[p*VLM_DATA_W +: VLM_DATA_W];
            if (MARGIN_HIGH_SEL[p]) begin
                req = margin_r[p];
            end
            clamped_nxt[p] = exceeds(req, ceiling_r[p]);
            if (clamped_nxt[p]) begin
                target_nxt[p] = ceiling_r[p];
            end else begin
                target_nxt[p] = req;
            end
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            for (int p = 0; p < PAGES; p++) begin
                target_r[p] <= '0;
            end
            clamped_r <= '0;
        end else begin
            for (int p = 0; p < PAGES; p++) begin
                target_r[p] <= target_nxt[p];
            end
            clamped_r <= clamped_nxt;
        end
    end

    // Ceiling words stay visible to the regulation loop
    genvar g;
    generate
        for (g = 0; g < PAGES; g++) begin : g_page
            assign TARGET[g*VLM_DATA_W +: VLM_DATA_W] = target_r[g];
            assign CEILING[g*VLM_DATA_W +: VLM_DATA_W] = ceiling_r[g];
        end
    endgenerate

    assign CLAMPED = clamped_r;
    assign RD_DATA = rd_data_r;
    assign RD_VALID = rd_valid_r;
    assign CMD_REJECT = reject_r;
    assign RANGE_WARN = warn_r;

endmodule
`default_nettype wire

// ==== tb/vlm_regs_asserts.sv ====
// Checker for the paged ceiling and margin-high register bank.
// Sees only the ports of vlm_regs; bound at the foot.
`timescale 1ns/100ps
`default_nettype none
module vlm_regs_asserts import vlm_pkg::*;
#(parameter int PAGES = 2, parameter int PAGE_W = 1) (
    // Clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // Command access
    input wire logic WR_EN,
    input wire logic RD_EN,
    input wire logic [PAGE_W-1:0] PAGE,
    input wire logic [VLM_CODE_W-1:0] CMD_CODE,
    input wire logic [VLM_DATA_W-1:0] WR_DATA,
    input wire logic RD_VALID,
    input wire logic CMD_REJECT,
    input wire logic RANGE_WARN,
    // Regulation target path
    input wire logic [PAGES-1:0] CLAMPED,
    input wire logic [PAGES*VLM_DATA_W-1:0] TARGET,
    input wire logic [PAGES*VLM_DATA_W-1:0] CEILING
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);
    logic wc;
    logic bad;
    assign wc = WR_EN && CMD_CODE == VLM_CMD_CEILING && PAGE == 0;
    assign bad = CMD_CODE != VLM_CMD_CEILING && CMD_CODE != VLM_CMD_MARGIN_HIGH;
    a_read_answer: assert property (RD_EN && !WR_EN && !bad
        |=> RD_VALID && !CMD_REJECT) else $error("read not answered");
    a_valid_cause: assert property (RD_VALID
        |-> $past(RD_EN) && !$past(WR_EN)) else $error("stray valid");
    a_reject_code: assert property ((WR_EN || RD_EN) && bad
        |=> CMD_REJECT && !RD_VALID) else $error("bad code taken");
    a_ceiling_write: assert property (wc
        |=> CEILING[15:0] == $past(WR_DATA)) else $error("ceiling not stored");
    a_other_page: assert property (wc
        |=> $stable(CEILING[31:16])) else $error("other page changed");
    a_clamp_bound: assert property (TARGET[15:0] <= $past(CEILING[15:0]))
        else $error("target above ceiling");
    a_clamp_flag: assert property (CLAMPED[0]
        |-> TARGET[15:0] == $past(CEILING[15:0])) else $error("bad clamp");
    a_span_warn: assert property (wc && WR_DATA > VLM_CEILING_SPAN_MAX
        |=> RANGE_WARN) else $error("no span warning");
    c_clamp: cover property (CLAMPED[0]);
    c_warn: cover property (RANGE_WARN);
    c_read: cover property (RD_VALID);
    c_reject: cover property (CMD_REJECT);
endmodule
bind vlm_regs vlm_regs_asserts #(.PAGES(PAGES), .PAGE_W(PAGE_W)) chk_i (
    .CLK, .NRST, .WR_EN, .RD_EN, .RD_VALID, .CMD_REJECT, .RANGE_WARN,
    .PAGE, .CMD_CODE, .WR_DATA, .CLAMPED, .TARGET, .CEILING);
`default_nettype wire

// ==== tb/vlm_host.sv ====
// Host model issuing one-word commands on the command port.
// Assumes a free-running CLK.
`timescale 1ns/100ps
`default_nettype none
module vlm_host (
    // Clock
    input wire logic clk,
    // Command access
    output logic pg,
    output logic we,
    output logic re,
    output logic [7:0] cc,
    output logic [15:0] wd
);
    initial {pg, we, re, cc, wd} = '0;
    // Values stay in range unless a warning is wanted
    task automatic op(input logic w, p, input logic [7:0] c,
                      input logic [15:0] d);
        @(posedge clk) #1 {we, re, pg, cc, wd} = {w, !w, p, c, d};
        @(posedge clk) #1 {we, re} = 2'b00;
    endtask
endmodule
`default_nettype wire

// ==== tb/test_vlm_regs.sv ====
// Bench for the paged ceiling and margin-high register bank.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/100ps
`default_nettype none
module test_vlm_regs;
    import vlm_pkg::*;
    logic CLK = 0, NRST = 0, PG, WE, RE, RV, REJ, WARN;
    logic [7:0] CC;
    logic [15:0] WD, RD;
    logic [31:0] NOM = 32'h0000_0FFF, TGT, CEIL;
    logic [1:0] MH = 2'h0, CLP;
    int n_fail = 0, n_compared = 0, cyc = 0;
    vlm_host host (.clk(CLK), .pg(PG), .we(WE), .re(RE), .cc(CC), .wd(WD));
    vlm_regs dut (.CLK, .NRST, .PAGE(PG), .CMD_CODE(CC), .WR_EN(WE),
        .WR_DATA(WD), .RD_EN(RE), .RD_DATA(RD), .RD_VALID(RV),
        .CMD_REJECT(REJ), .RANGE_WARN(WARN), .NOMINAL_TARGET(NOM),
        .MARGIN_HIGH_SEL(MH), .TARGET(TGT), .CLAMPED(CLP), .CEILING(CEIL));
    task automatic chk(input logic [15:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        if (n_fail == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial forever #12.5 CLK = ~CLK;
    always @(posedge CLK) if (++cyc > 500) begin
        n_fail++;
        final_report;
    end
    initial begin
        repeat (4) @(posedge CLK);
        #1 NRST = 1;
        for (int p = 0; p < 2; p++) begin
            host.op(1'b0, p[0], VLM_CMD_CEILING, 16'h0000);
            chk(RD, VLM_CEILING_RST);
            chk({15'h0, RV}, 16'h1);
            host.op(1'b0, p[0], VLM_CMD_MARGIN_HIGH, 16'h0000);
            chk(RD, VLM_MARGIN_HIGH_RST);
        end
        chk(TGT[15:0], VLM_CEILING_RST);
        chk({15'h0, CLP[0]}, 16'h1);
        chk(TGT[31:16], 16'h0000);
        host.op(1'b1, 1'b1, VLM_CMD_CEILING, 16'h0500);
        chk({15'h0, WARN}, 16'h0);
        host.op(1'b0, 1'b1, VLM_CMD_CEILING, 16'h0000);
        chk(RD, 16'h0500);
        chk(CEIL[15:0], VLM_CEILING_RST);
        chk(CEIL[31:16], 16'h0500);
        host.op(1'b1, 1'b1, VLM_CMD_MARGIN_HIGH, 16'h0600);
        chk({15'h0, WARN}, 16'h1);
        host.op(1'b1, 1'b0, VLM_CMD_MARGIN_HIGH, 16'h0700);
        chk({15'h0, WARN}, 16'h0);
        MH = 2'h3;
        #50;
        chk(TGT[15:0], 16'h0700);
        chk({15'h0, CLP[0]}, 16'h0);
        chk(TGT[31:16], 16'h0500);
        chk({15'h0, CLP[1]}, 16'h1);
        host.op(1'b1, 1'b0, VLM_CMD_CEILING, 16'h0600);
        #50;
        chk(TGT[15:0], 16'h0600);
        chk({15'h0, CLP[0]}, 16'h1);
        host.op(1'b1, 1'b0, VLM_CMD_CEILING, VLM_CEILING_SPAN_MAX);
        chk({15'h0, WARN}, 16'h0);
        host.op(1'b1, 1'b0, VLM_CMD_CEILING, VLM_CEILING_SPAN_MAX + 16'h1);
        chk({15'h0, WARN}, 16'h1);
        host.op(1'b0, 1'b0, VLM_CMD_CEILING, 16'h0000);
        chk(RD, VLM_CEILING_SPAN_MAX + 16'h1);
        host.op(1'b0, 1'b1, 8'h26, 16'h0000);
        chk({15'h0, REJ}, 16'h1);
        chk({15'h0, RV}, 16'h0);
        host.op(1'b1, 1'b1, 8'h26, 16'h0123);
        chk({15'h0, REJ}, 16'h1);
        host.op(1'b0, 1'b1, VLM_CMD_CEILING, 16'h0000);
        chk(RD, 16'h0500);
        chk({15'h0, REJ}, 16'h0);
        NRST = 0;
        repeat (2) @(posedge CLK);
        #1 NRST = 1;
        host.op(1'b0, 1'b1, VLM_CMD_CEILING, 16'h0000);
        chk(RD, VLM_CEILING_RST);
        host.op(1'b0, 1'b0, VLM_CMD_MARGIN_HIGH, 16'h0000);
        chk(RD, VLM_MARGIN_HIGH_RST);
        chk(TGT[15:0], VLM_MARGIN_HIGH_RST);
        final_report;
    end
endmodule
`default_nettype wire
